/* File: cspsl_pkg.sv */
// shared constants, types and helpers of the serial configuration port
// assumes both ends are compiled against this package
// Behaviour
// [R01] select is active low and gates everything
// [R02] frame starts on first rise after select falls
// [R03] 16-bit instruction, then counted data bytes
// [R04] select may pause short transfers between bytes
// [R05] count code 11 streams until select rises
// [R06] select rising mid-byte resets to instruction wait
// [R07] select tied low gives two-wire operation
// [R08] two-wire streaming cannot be left
// [R09] two-wire hosts avoid streaming transfers
// [R10] instruction carries read or write direction
// [R11] read turns data pin to output
// [R12] msb first at reset, lsb via config
// [R13] clock and select inputs, data pin shared
// [R14] device samples data on rising clock edges
// [R15] drive after falling edge, release after rising
// [R16] msb-first streams name the highest address
// [R17] instruction: direction, count, 13-bit address
// [R18] address steps down msb-first, up lsb-first
// [R19] byte written only when all eight arrived
`default_nettype none
package cspsl_pkg;

   // ****************************************
   // instruction layout
   // ****************************************
   localparam int INSTR_BITS = 16;
   localparam int BYTE_BITS = 8;
   localparam int ADDR_W = 13;
   localparam int RW_POS = 15;
   localparam int CNT_HI_POS = 14;
   localparam int CNT_LO_POS = 13;
   localparam logic [1:0] CNT_STREAM = 2'h3;

   // ****************************************
   // device configuration register
   // ****************************************
   localparam logic [12:0] CFG_ADDR = 13'h000;
   localparam int LSB_FIRST_POS = 6;
   localparam logic [7:0] CFG_RESET = 8'h00;

   // ****************************************
   // host command registers
   // ****************************************
   localparam logic [1:0] HREG_INSTR = 2'h0;
   localparam logic [1:0] HREG_TXDATA = 2'h1;
   localparam logic [1:0] HREG_RXDATA = 2'h2;
   localparam logic [1:0] HREG_STATUS = 2'h3;
   localparam int STAT_BUSY_POS = 0;
   localparam int STAT_LSB_POS = 1;

   // ****************************************
   // timing
   // ****************************************
   localparam int SYS_PERIOD_PS = 50000;
   localparam int T_HIGH_MIN_PS = 16000;
   localparam int SAMPLER_CYC = 3;
   // half period also covers the two-flop sampler on returned data
   localparam int SCLK_HALF_CYC =
      ((T_HIGH_MIN_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS) + SAMPLER_CYC;

   typedef enum {DS_INSTR, DS_WRITE, DS_READ} cspsl_dev_state_t;
   typedef enum {HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL} cspsl_host_state_t;

   // position of the i-th serial bit inside a byte
   function automatic logic [2:0] bit_index(input logic lsb_first, input logic [2:0] i);
      bit_index = lsb_first ? i : 3'h7 - i;
   endfunction

endpackage
`default_nettype wire

/* File: cspsl_if.sv */
// the serial link between host and device
// assumes the data pin carries a pull-up when nobody drives it
`timescale 1ns/10ps
`default_nettype none
interface cspsl_if;
   logic sclk;
   logic port_select_n;
   logic sdio_host_o;
   logic sdio_host_oe;
   logic sdio_dev_o;
   logic sdio_dev_oe;
   wire sdio;

   // host wins a clash so a stuck device cannot hide host data
   assign sdio = sdio_host_oe ? sdio_host_o : (sdio_dev_oe ? sdio_dev_o : 1'b1);

   modport dev (
      input sclk,
      input port_select_n,
      input sdio,
      output sdio_dev_o,
      output sdio_dev_oe
   );

   modport host (
      output sclk,
      output port_select_n,
      output sdio_host_o,
      output sdio_host_oe,
      input sdio
   );
endinterface
`default_nettype wire

/* File: cspsl_dev.sv */
// device end: instruction decode, byte register space, readback driver
// assumes the link clock is made by the host and stops outside frames
`timescale 1ns/10ps
`default_nettype none
module cspsl_dev #(
   parameter int MEM_AW = 6
) (
   // link
   cspsl_if.dev lnk,
   // system side
   input wire logic clk_sys,
   input wire logic rst,
   // committed writes and port order, in the system domain
   output logic wr_valid,
   output logic [12:0] wr_addr,
   output logic [7:0] wr_data,
   output logic lsb_first
);

   // ****************************************
   // link-domain state
   // ****************************************
   // select and data are timed against the link clock by the host,
   // so they are sampled directly on its edges
   cspsl_pkg::cspsl_dev_state_t state;
   logic [3:0] cnt;
   logic [15:0] ins_sr;
   logic [7:0] wbyte;
   logic [1:0] remain;
   logic stream;
   logic [12:0] addr;
   logic gap_tog;
   logic gap_ack;
   logic [7:0] mem [0:(1 << MEM_AW) - 1];
   logic sdo;
   logic drive_neg;
   logic wr_tog;
   logic [12:0] wr_addr_l;
   logic [7:0] wr_data_l;

   logic lsb_link;
   logic fresh;
   logic restart;
   logic bit_in;
   logic [15:0] next_ins;
   logic [7:0] next_wbyte;
   logic byte_end;
   logic commit;
   logic [12:0] next_addr;
   logic in_range;
   logic [7:0] rd_byte;

   assign lsb_link = mem[0][cspsl_pkg::LSB_FIRST_POS]; // R12
   assign bit_in = lnk.sdio;
   assign in_range = (addr >> MEM_AW) == 13'h0000;
   assign rd_byte = in_range ? mem[addr[MEM_AW - 1:0]] : 8'h00;

   // ****************************************
   // select gap detector
   // ****************************************
   // counts rising select edges; clocked by select itself because
   // the link clock may not run while select is high
   always_ff @(posedge lnk.port_select_n or posedge rst) begin
      if (rst) begin
         gap_tog <= 1'b0;
      end else begin
         gap_tog <= ~gap_tog;
      end
   end

   always_comb begin
      fresh = gap_tog != gap_ack; // R02
      // a pause is only legal on a byte boundary of an instruction or of counted data
      restart = fresh && ((cnt[2:0] != 3'h0) || (stream && state != cspsl_pkg::DS_INSTR)); // R04 R06
      if (lsb_link) begin
         next_ins = {bit_in, ins_sr[15:1]};
         next_wbyte = {bit_in, wbyte[7:1]};
      end else begin
         next_ins = {ins_sr[14:0], bit_in};
         next_wbyte = {wbyte[6:0], bit_in};
      end
      byte_end = !restart && state != cspsl_pkg::DS_INSTR && cnt[2:0] == 3'h7;
      commit = byte_end && state == cspsl_pkg::DS_WRITE && !lnk.port_select_n; // R19
      next_addr = lsb_link ? addr + 13'h0001 : addr - 13'h0001; // R18
   end

   always_ff @(posedge lnk.sclk or posedge rst) begin
      if (rst) begin
         gap_ack <= 1'b0;
      end else if (!lnk.port_select_n) begin
         gap_ack <= gap_tog;
      end
   end

   // ****************************************
   // frame sequencer
   // ****************************************
   // reset leaves the port waiting for an instruction, which is the
   // only synchronisation a tied-low select gets
   always_ff @(posedge lnk.sclk or posedge rst) begin // R07 R14
      if (rst) begin
         state <= cspsl_pkg::DS_INSTR;
         cnt <= 4'h0;
         ins_sr <= 16'h0000;
         wbyte <= 8'h00;
         remain <= 2'h0;
         stream <= 1'b0;
         addr <= 13'h0000;
      end else if (!lnk.port_select_n) begin // R01
         if (restart || state == cspsl_pkg::DS_INSTR) begin
            ins_sr <= next_ins;
            if (restart) begin
               state <= cspsl_pkg::DS_INSTR;
               cnt <= 4'h1;
            end else if (cnt == 4'hf) begin // R03
               cnt <= 4'h0;
               addr <= next_ins[12:0]; // R17
               remain <= next_ins[cspsl_pkg::CNT_HI_POS:cspsl_pkg::CNT_LO_POS];
               stream <= next_ins[cspsl_pkg::CNT_HI_POS:cspsl_pkg::CNT_LO_POS]
                  == cspsl_pkg::CNT_STREAM; // R05
               if (next_ins[cspsl_pkg::RW_POS]) begin // R10
                  state <= cspsl_pkg::DS_READ;
               end else begin
                  state <= cspsl_pkg::DS_WRITE;
               end
            end else begin
               cnt <= cnt + 4'h1;
            end
         end else begin
            wbyte <= next_wbyte;
            if (byte_end) begin
               cnt <= 4'h0;
               addr <= next_addr; // R18
               // streaming never ends here; only select does, so a tied-low
               // select keeps streaming for good
               if (!stream) begin // R05 R08
                  if (remain == 2'h0) begin
                     state <= cspsl_pkg::DS_INSTR;
                  end else begin
                     remain <= remain - 2'h1;
                  end
               end
            end else begin
               cnt <= cnt + 4'h1;
            end
         end
      end
   end

   // ****************************************
   // register space
   // ****************************************
   always_ff @(posedge lnk.sclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < (1 << MEM_AW); i++) begin
            mem[i] <= 8'h00;
         end
         mem[0] <= cspsl_pkg::CFG_RESET; // R12
      end else if (commit && in_range) begin // R19
         mem[addr[MEM_AW - 1:0]] <= next_wbyte;
      end
   end

   // ****************************************
   // readback driver
   // ****************************************
   always_ff @(negedge lnk.sclk or posedge rst) begin // R15
      if (rst) begin
         sdo <= 1'b0;
         drive_neg <= 1'b0;
      end else begin
         sdo <= rd_byte[cspsl_pkg::bit_index(lsb_link, cnt[2:0])];
         drive_neg <= state == cspsl_pkg::DS_READ;
      end
   end

   // enable drops straight after the last rising edge, not at the next fall;
   // a stream read cut by select must not drive into the next instruction
   assign lnk.sdio_dev_o = sdo;
   assign lnk.sdio_dev_oe = drive_neg && state == cspsl_pkg::DS_READ
      && !lnk.port_select_n && !restart; // R06 R11 R13 R15

   // ****************************************
   // write report towards the system clock
   // ****************************************
   always_ff @(posedge lnk.sclk or posedge rst) begin
      if (rst) begin
         wr_tog <= 1'b0;
         wr_addr_l <= 13'h0000;
         wr_data_l <= 8'h00;
      end else if (commit) begin
         wr_tog <= ~wr_tog;
         wr_addr_l <= addr;
         wr_data_l <= next_wbyte;
      end
   end

   logic [2:0] tog_sync;
   logic [1:0] lsb_sync;

   // held words are stable for a whole byte, far longer than the sampler
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tog_sync <= 3'h0;
         lsb_sync <= 2'h0;
         wr_valid <= 1'b0;
         wr_addr <= 13'h0000;
         wr_data <= 8'h00;
         lsb_first <= 1'b0;
      end else begin
         tog_sync <= {tog_sync[1:0], wr_tog};
         lsb_sync <= {lsb_sync[0], lsb_link};
         lsb_first <= lsb_sync[1];
         wr_valid <= tog_sync[2] != tog_sync[1];
         if (tog_sync[2] != tog_sync[1]) begin
            wr_addr <= wr_addr_l;
            wr_data <= wr_data_l;
         end
      end
   end

endmodule // cspsl_dev
`default_nettype wire

/* File: cspsl_host.sv */
// host end: command registers, link clock divider, frame shifter
// assumes software writes the data word before the instruction
`timescale 1ns/10ps
`default_nettype none
module cspsl_host #(
   parameter int HALF_CYC = cspsl_pkg::SCLK_HALF_CYC
) (
   // link
   cspsl_if.host lnk,
   // system
   input wire logic clk_sys,
   input wire logic rst,
   // command port
   input wire logic [1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);

   cspsl_pkg::cspsl_host_state_t state;
   logic [15:0] instr;
   logic [31:0] txdata;
   logic [31:0] rxdata;
   logic lsb;
   logic [7:0] div;
   logic [5:0] bitn;
   logic [5:0] last_bit;
   logic [1:0] sdi_sync;
   logic sclk_r;
   logic sel_n_r;
   logic sdo_r;
   logic oe_r;
   logic busy;
   logic tick;
   logic is_read;

   assign busy = state != cspsl_pkg::HS_IDLE;
   assign tick = div == 8'(HALF_CYC - 1);
   assign is_read = instr[cspsl_pkg::RW_POS];

   // data bit position of serial bit i, counted from the first instruction bit
   function automatic logic [4:0] data_pos(input logic lsb_first, input logic [5:0] i);
      logic [5:0] j;
      j = i - 6'(cspsl_pkg::INSTR_BITS);
      data_pos = {j[4:3], cspsl_pkg::bit_index(lsb_first, j[2:0])};
   endfunction

   function automatic logic tx_bit(input logic [5:0] i);
      if (i < 6'(cspsl_pkg::INSTR_BITS)) begin
         tx_bit = instr[lsb ? i[3:0] : 4'hf - i[3:0]];
      end else begin
         tx_bit = txdata[data_pos(lsb, i)];
      end
   endfunction

   // ****************************************
   // command registers
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txdata <= 32'h0000_0000;
         lsb <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         // settings are frozen while a frame runs
         if (wr && !busy && addr == cspsl_pkg::HREG_TXDATA) begin
            txdata <= wdata;
         end
         if (wr && !busy && addr == cspsl_pkg::HREG_STATUS) begin
            lsb <= wdata[cspsl_pkg::STAT_LSB_POS];
         end
         rdata <= 32'h0000_0000;
         if (rd) begin
            case (addr)
               cspsl_pkg::HREG_INSTR: rdata <= {16'h0000, instr};
               cspsl_pkg::HREG_TXDATA: rdata <= txdata;
               cspsl_pkg::HREG_RXDATA: rdata <= rxdata;
               default: rdata <= {30'h0, lsb, busy};
            endcase
         end
      end
   end

   // ****************************************
   // frame shifter
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sdi_sync <= 2'h0;
      end else begin
         sdi_sync <= {sdi_sync[0], lnk.sdio};
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= cspsl_pkg::HS_IDLE;
         instr <= 16'h0000;
         rxdata <= 32'h0000_0000;
         div <= 8'h00;
         bitn <= 6'h00;
         last_bit <= 6'h00;
         sclk_r <= 1'b0;
         sel_n_r <= 1'b1;
         sdo_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         div <= tick ? 8'h00 : div + 8'h01;
         case (state)
            cspsl_pkg::HS_IDLE: begin
               div <= 8'h00;
               if (wr && addr == cspsl_pkg::HREG_INSTR) begin
                  instr <= wdata[15:0];
                  // count code 11 is run as four streamed bytes
                  last_bit <= 6'(cspsl_pkg::INSTR_BITS - 1)
                     + {1'b0, wdata[14:13], 3'h0} + 6'h08;
                  rxdata <= 32'h0000_0000;
                  bitn <= 6'h00;
                  sel_n_r <= 1'b0; // R01 R02
                  oe_r <= 1'b1;
                  sdo_r <= lsb ? wdata[0] : wdata[15];
                  state <= cspsl_pkg::HS_LOW;
               end
            end
            cspsl_pkg::HS_LOW: begin
               if (tick) begin
                  sclk_r <= 1'b1;
                  if (is_read && bitn >= 6'(cspsl_pkg::INSTR_BITS)) begin
                     rxdata[data_pos(lsb, bitn)] <= sdi_sync[1];
                  end
                  state <= cspsl_pkg::HS_HIGH;
               end
            end
            cspsl_pkg::HS_HIGH: begin
               if (tick) begin
                  sclk_r <= 1'b0;
                  if (bitn == 6'(cspsl_pkg::INSTR_BITS - 1) && is_read) begin
                     oe_r <= 1'b0; // R13
                  end
                  if (bitn == last_bit) begin
                     state <= cspsl_pkg::HS_TAIL;
                  end else begin
                     bitn <= bitn + 6'h01;
                     sdo_r <= tx_bit(bitn + 6'h01);
                     state <= cspsl_pkg::HS_LOW;
                  end
               end
            end
            cspsl_pkg::HS_TAIL: begin
               if (tick) begin
                  // select always rises after a frame, so a stream is always left
                  sel_n_r <= 1'b1; // R09
                  oe_r <= 1'b0;
                  state <= cspsl_pkg::HS_IDLE;
               end
            end
            default: state <= cspsl_pkg::HS_IDLE;
         endcase
      end
   end

   assign lnk.sclk = sclk_r;
   assign lnk.port_select_n = sel_n_r;
   assign lnk.sdio_host_o = sdo_r;
   assign lnk.sdio_host_oe = oe_r;

endmodule // cspsl_host
`default_nettype wire

/* File: cspsl_checker.sv */
// concurrent checks on the serial link between host and device
// assumes a host half period of 4 system cycles, as the bench sets it
`timescale 1ns/10ps
`default_nettype none
module cspsl_checker (
   // system
   input wire logic clk_sys,
   input wire logic rst,
   // link
   input wire logic sclk,
   input wire logic port_select_n,
   input wire logic sdio_host_o,
   input wire logic sdio_host_oe,
   input wire logic sdio_dev_o,
   input wire logic sdio_dev_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ****************************************
   // link clock rises per frame
   // ****************************************
   logic sclk_q;
   logic [6:0] rise_cnt;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_q <= 1'b0;
         rise_cnt <= 7'h00;
      end else begin
         sclk_q <= sclk;
         if (port_select_n) begin
            rise_cnt <= 7'h00;
         end else if (sclk && !sclk_q) begin
            rise_cnt <= rise_cnt + 7'h01;
         end
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   a_idle_clock_low: assert property (port_select_n |-> !sclk)
      else $error("link clock moved outside a frame");
   a_frame_opening: assert property ($fell(port_select_n) |-> (!sclk && sdio_host_oe) [*4])
      else $error("frame did not open with clock low and host driving");
   a_whole_frame: assert property ($rose(port_select_n) |-> rise_cnt[2:0] == 3'h0 && rise_cnt >= 7'h18)
      else $error("frame ended off a byte boundary or without instruction");
   a_no_clash: assert property (!(sdio_host_oe && sdio_dev_oe))
      else $error("both ends drive the data pin");
   a_dev_in_frame: assert property (sdio_dev_oe |-> !port_select_n)
      else $error("device drives data pin outside a frame");
   a_turn_on_low: assert property ($rose(sdio_dev_oe) |-> !sclk)
      else $error("device turned on while clock high");
   a_turn_off_high: assert property ($fell(sdio_dev_oe) && !port_select_n |-> sclk)
      else $error("device released pin while clock low");
   a_host_data_held: assert property ($rose(sclk) && sdio_host_oe |-> $stable(sdio_host_o))
      else $error("host data changed at rising clock");
   a_dev_data_held: assert property (sdio_dev_oe && sclk && $past(sclk) |-> $stable(sdio_dev_o))
      else $error("device data changed while clock high");
   a_clock_high_width: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
      else $error("link clock high phase has wrong width");

   c_read_turn: cover property ($rose(sdio_dev_oe));
   c_single_byte: cover property ($rose(port_select_n) && rise_cnt == 7'h18);
   c_stream_frame: cover property ($rose(port_select_n) && rise_cnt == 7'h30);
endmodule // cspsl_checker
`default_nettype wire

/* File: tb_config_serial_port_slave.sv */
// self-checking bench: host command port drives frames into the device
// assumes host and device both start in msb-first order after reset
`timescale 1ns/10ps
`default_nettype none
module tb_config_serial_port_slave;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic wr_valid;
   logic [12:0] wr_addr;
   logic [7:0] wr_data;
   logic lsb_first;
   logic [20:0] got[$];
   logic [31:0] s;
   int error_cnt = 0;
   int samples_checked = 0;

   always #25 clk_sys = ~clk_sys;

   cspsl_if lnk_if();
   cspsl_host #(.HALF_CYC(4)) i_cspsl_host (.lnk(lnk_if), .clk_sys(clk_sys), .rst(rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   cspsl_dev #(.MEM_AW(6)) i_cspsl_dev (.lnk(lnk_if), .clk_sys(clk_sys), .rst(rst),
      .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .lsb_first(lsb_first));
   cspsl_checker chk (.clk_sys(clk_sys), .rst(rst), .sclk(lnk_if.sclk),
      .port_select_n(lnk_if.port_select_n), .sdio_host_o(lnk_if.sdio_host_o),
      .sdio_host_oe(lnk_if.sdio_host_oe), .sdio_dev_o(lnk_if.sdio_dev_o),
      .sdio_dev_oe(lnk_if.sdio_dev_oe));

   // committed device writes, oldest first
   always @(posedge clk_sys) begin
      if (wr_valid === 1'b1) begin
         got.push_back({wr_addr, wr_data});
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // a gap cycle after each strobe keeps one assignment per time step
   task automatic cmd_wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   task automatic cmd_rd(input logic [1:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic wait_idle;
      logic [31:0] st;
      st = 32'h1;
      for (int i = 0; i < 2000 && st[0] !== 1'b0; i++) cmd_rd(cspsl_pkg::HREG_STATUS, st);
      check(st[0], 1'b0);
   endtask

   task automatic xfer(input logic rdn, input logic [1:0] cnt, input logic [12:0] a,
                       input logic [31:0] tx, output logic [31:0] rx);
      cmd_wr(cspsl_pkg::HREG_TXDATA, tx);
      cmd_wr(cspsl_pkg::HREG_INSTR, {16'h0, rdn, cnt, a});
      wait_idle();
      cmd_rd(cspsl_pkg::HREG_RXDATA, rx);
   endtask

   task automatic expect_writes(input logic [12:0] a, input logic up, input int n,
                                input logic [31:0] tx);
      logic [12:0] ea;
      for (int i = 0; i < 40 && got.size() < n; i++) @(posedge clk_sys);
      repeat (8) @(posedge clk_sys);
      check(got.size(), n);
      for (int k = 0; k < n; k++) begin
         ea = up ? a + k[12:0] : a - k[12:0];
         check({11'h0, got[k]}, {11'h0, ea, tx[8*k +: 8]});
      end
      got.delete();
   endtask

   // every count code: write, then read the same bytes back
   task automatic count_sweep(input logic [12:0] a, input logic up);
      logic [31:0] tx;
      logic [31:0] rx;
      logic [31:0] m;
      for (int n = 0; n < 4; n++) begin
         tx = 32'h8c4e2a17 ^ (n * 32'h01010101);
         m = (n == 3) ? 32'hffffffff : (32'h1 << (8 * (n + 1))) - 32'h1;
         xfer(1'b0, n[1:0], a, tx, rx);
         expect_writes(a, up, n + 1, tx);
         xfer(1'b1, n[1:0], a, 32'h0, rx);
         check(rx & m, tx & m);
      end
   endtask

   task automatic give_verdict;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      logic [31:0] rx;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      cmd_rd(cspsl_pkg::HREG_STATUS, s);
      check(s[1:0], 2'h0);
      check(lsb_first, 1'b0);
      count_sweep(13'h030, 1'b0);
      // busy host must ignore new data and a second instruction
      cmd_wr(cspsl_pkg::HREG_TXDATA, 32'h5a);
      cmd_wr(cspsl_pkg::HREG_INSTR, {16'h0, 3'h0, 13'h007});
      cmd_wr(cspsl_pkg::HREG_TXDATA, 32'hff);
      cmd_wr(cspsl_pkg::HREG_INSTR, {16'h0, 3'h0, 13'h008});
      wait_idle();
      expect_writes(13'h007, 1'b0, 1, 32'h5a);
      // space beyond the implemented bytes reads as zero
      xfer(1'b1, 2'h0, 13'h100, 32'h0, rx);
      check(rx[7:0], 8'h00);
      // switch both ends to lsb-first order
      xfer(1'b0, 2'h0, cspsl_pkg::CFG_ADDR, 32'h40, rx);
      expect_writes(cspsl_pkg::CFG_ADDR, 1'b0, 1, 32'h40);
      for (int i = 0; i < 20 && lsb_first !== 1'b1; i++) @(posedge clk_sys);
      check(lsb_first, 1'b1);
      cmd_wr(cspsl_pkg::HREG_STATUS, 32'h2);
      cmd_rd(cspsl_pkg::HREG_STATUS, s);
      check(s[1:0], 2'h2);
      count_sweep(13'h021, 1'b1);
      give_verdict();
   end

   // whole run needs roughly 5600 cycles
   initial begin
      repeat (60000) @(posedge clk_sys);
      error_cnt++;
      give_verdict();
   end
endmodule // tb_config_serial_port_slave
`default_nettype wire
